// ### include/acr_defs.svh
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH
// What this block does
// - 16-bit status word read when target is 11
// - Status word reads 00C0 at power-up, all fields cleared
// - Status bits 15 to 10 read zero
// - Bits 9 and 8 show power state
// - Bits 7 and 6 read one
// - Bit 5 shows input range
// - Bit 4 shows conversion or calibration busy
// - Bit 3 shows calibration type
// - Bit 0 calibration running, bits 2:1 target
// - Ten calibration registers, host readable and writable
// - Calibration run updates calibration registers
// - Target bits select ten, two, offset, gain
// - Pointer resets on control write with launch bit zero, or on wrap
// - Reset points at gain, except offset-only
// - Pointer advances after each full access, except one in the same cycle as a control write
// - Byte mode advances after high byte only
// - Abandoned sequence resets on next control write with launch bit zero
// - Calibration read returns two top bits zero
// - Control bits 7 and 6 select read target
// - Launch bit zero makes target an address
`define ACR_CAL_COUNT 10
`define ACR_IDX_GAIN 4'h0
`define ACR_IDX_OFFSET 4'h1
`define ACR_IDX_LAST 4'h9
`define ACR_CTL_RDT_HI 7
`define ACR_CTL_RDT_LO 6
`define ACR_CTL_PWR_HI 9
`define ACR_CTL_PWR_LO 8
`define ACR_CTL_RANGE 5
`define ACR_CTL_CONV 4
`define ACR_CTL_CALTYPE 3
`define ACR_CTL_TGT_HI 2
`define ACR_CTL_TGT_LO 1
`define ACR_CTL_LAUNCH 0
`define ACR_RDT_CAL 2'h2
`define ACR_RDT_STATUS 2'h3
`define ACR_STATUS_RESET 16'h0000
`define ACR_CAL_RESET 14'h0000
`define ACR_CAL_MASK 16'h3FFF
`endif

// ### include/acr_pkg.sv
package acr_pkg;
    typedef enum logic [3:0] {
        ACR_SEL_ALL = 4'h1,
        ACR_SEL_GAIN_OFFSET = 4'h2,
        ACR_SEL_OFFSET = 4'h4,
        ACR_SEL_GAIN = 4'h8
    } acr_sel_t;
    typedef logic [13:0] acr_coef_t;
endpackage

// ### include/acr_ptr_if.sv
interface acr_ptr_if;
    logic restart;
    logic advance;
    logic [1:0] target;
    logic [3:0] index;
    modport ctl (output restart, output advance, output target,
                 input index);
    modport ptr (input restart, input advance, input target,
                 output index);
endinterface

// ### src/acr_ptr.sv
`include "acr_defs.svh"
module acr_ptr (
    input wire logic clock, // Core clock
    input wire logic sys_rst, // Async reset, high
    acr_ptr_if.ptr pif // Pointer control
);
    acr_pkg::acr_sel_t sel;
    logic [3:0] first_idx;
    logic [3:0] last_idx;
    logic [3:0] index_q;

    always_comb
    begin
        case (pif.target)
            2'h0: sel = acr_pkg::ACR_SEL_ALL;
            2'h1: sel = acr_pkg::ACR_SEL_GAIN_OFFSET;
            2'h2: sel = acr_pkg::ACR_SEL_OFFSET;
            default: sel = acr_pkg::ACR_SEL_GAIN;
        endcase
    end

    always_comb
    begin
        first_idx = `ACR_IDX_GAIN;
        last_idx = `ACR_IDX_GAIN;
        case (sel)
            acr_pkg::ACR_SEL_ALL: last_idx = `ACR_IDX_LAST;
            acr_pkg::ACR_SEL_GAIN_OFFSET: last_idx = `ACR_IDX_OFFSET;
            acr_pkg::ACR_SEL_OFFSET:
            begin
                first_idx = `ACR_IDX_OFFSET;
                last_idx = `ACR_IDX_OFFSET;
            end
            default: last_idx = `ACR_IDX_GAIN;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            index_q <= `ACR_IDX_GAIN;
        else if (pif.restart)
            index_q <= first_idx;
        else if (pif.advance)
        begin
            if (index_q == last_idx)
                index_q <= first_idx;
            else
                index_q <= index_q + 4'h1;
        end
    end

    assign pif.index = index_q;
endmodule

// ### src/acr_regs.sv
`include "acr_defs.svh"
module acr_regs (
    input wire logic clock, // Core clock
    input wire logic sys_rst, // Async reset, high
    input wire logic ctl_wr, // Control word write strobe
    input wire logic [15:0] ctl_data, // Control word
    input wire logic cal_wr, // Calibration data write strobe
    input wire logic cal_rd, // Calibration data read strobe
    input wire logic byte_mode, // 8-bit bus mode
    input wire logic high_byte_select, // High byte in byte mode
    input wire logic [15:0] wr_data, // Write data
    input wire logic conv_active, // Converter busy
    input wire logic cal_active, // Calibration engine running
    input wire logic cal_update, // Engine result strobe
    input wire logic [3:0] cal_update_idx, // Engine result index
    input wire logic [13:0] cal_update_data, // Engine result
    output logic [15:0] rd_data, // Read data
    output logic [1:0] power_state, // Power state bits
    output logic input_range_select, // 1 bipolar
    output logic cal_type_select, // 1 system calibration
    output logic cal_launch, // Calibration start level
    output logic conv_start, // Conversion start level
    output logic [1:0] cal_target, // Calibration target
    output logic [3:0] cal_index // Current pointer
);
    logic [1:0] read_target_q;
    logic [1:0] power_state_q;
    logic range_q;
    logic cal_type_q;
    logic [1:0] cal_target_q;
    logic launch_q;
    logic conv_q;
    logic [15:0] status;
    logic [15:0] rd_d;
    logic [15:0] rd_q;
    logic [7:0] low_byte_q;
    logic access;
    logic [15:0] acc_data;
    acr_pkg::acr_coef_t coef_q [`ACR_CAL_COUNT];
    acr_ptr_if pif ();

    acr_ptr u_ptr (
        .clock(clock),
        .sys_rst(sys_rst),
        .pif(pif)
    );

    // Launch and start read back until the engine finishes
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            read_target_q <= 2'h0;
            power_state_q <= 2'h0;
            range_q <= 1'b0;
            cal_type_q <= 1'b0;
            cal_target_q <= 2'h0;
        end
        else if (ctl_wr)
        begin
            read_target_q <= ctl_data[`ACR_CTL_RDT_HI:`ACR_CTL_RDT_LO];
            power_state_q <= ctl_data[`ACR_CTL_PWR_HI:`ACR_CTL_PWR_LO];
            range_q <= ctl_data[`ACR_CTL_RANGE];
            cal_type_q <= ctl_data[`ACR_CTL_CALTYPE];
            cal_target_q <= ctl_data[`ACR_CTL_TGT_HI:`ACR_CTL_TGT_LO];
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            launch_q <= 1'b0;
            conv_q <= 1'b0;
        end
        else
        begin
            // Set wins over the engine's self-clear
            launch_q <= (ctl_wr & ctl_data[`ACR_CTL_LAUNCH])
                | (launch_q & cal_active);
            conv_q <= (ctl_wr & ctl_data[`ACR_CTL_CONV])
                | (conv_q & conv_active);
        end
    end

    // Only a full word or the high byte counts as one access
    assign access = (cal_wr | cal_rd) & (~byte_mode | high_byte_select);
    assign pif.restart = ctl_wr & ~ctl_data[`ACR_CTL_LAUNCH];
    assign pif.advance = access & ~ctl_wr;
    // A restart must see the target being written, not the stale one
    assign pif.target = pif.restart
        ? ctl_data[`ACR_CTL_TGT_HI:`ACR_CTL_TGT_LO] : cal_target_q;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            low_byte_q <= 8'h00;
        else if (cal_wr & byte_mode & ~high_byte_select)
            low_byte_q <= wr_data[7:0];
    end

    assign acc_data = byte_mode ? {wr_data[7:0], low_byte_q} : wr_data;

    genvar gi;
    generate
        for (gi = 0; gi < `ACR_CAL_COUNT; gi++)
        begin : g_coef
            always_ff @(posedge clock or posedge sys_rst)
            begin
                if (sys_rst)
                    coef_q[gi] <= `ACR_CAL_RESET;
                else if (cal_update && cal_update_idx == 4'(gi))
                    coef_q[gi] <= cal_update_data;
                else if (access && cal_wr && pif.index == 4'(gi))
                    coef_q[gi] <= acc_data[13:0];
            end
        end
    endgenerate

    always_comb
    begin
        status = `ACR_STATUS_RESET;
        status[`ACR_CTL_PWR_HI:`ACR_CTL_PWR_LO] = power_state_q;
        status[`ACR_CTL_RDT_HI:`ACR_CTL_RDT_LO] = 2'h3;
        status[`ACR_CTL_RANGE] = range_q;
        status[`ACR_CTL_CONV] = conv_active | cal_active;
        status[`ACR_CTL_CALTYPE] = cal_type_q;
        status[`ACR_CTL_TGT_HI:`ACR_CTL_TGT_LO] = cal_target_q;
        status[`ACR_CTL_LAUNCH] = cal_active;
    end

    // Other targets belong to the conversion path; they read zero here
    always_comb
    begin
        rd_d = 16'h0000;
        if (read_target_q == `ACR_RDT_STATUS)
            rd_d = status;
        else if (read_target_q == `ACR_RDT_CAL)
            rd_d = {2'h0, coef_q[pif.index]} & `ACR_CAL_MASK;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            rd_q <= `ACR_STATUS_RESET;
        else if (byte_mode)
            rd_q <= high_byte_select ? {8'h00, rd_d[15:8]}
                : {8'h00, rd_d[7:0]};
        else
            rd_q <= rd_d;
    end

    assign rd_data = rd_q;
    assign power_state = power_state_q;
    assign input_range_select = range_q;
    assign cal_type_select = cal_type_q;
    assign cal_launch = launch_q;
    assign conv_start = conv_q;
    assign cal_target = cal_target_q;
    assign cal_index = pif.index;
endmodule

// ### test/acr_regs_assertions.sv
module acr_chk (
    input wire logic clock, // Clock
    input wire logic sys_rst, // Reset
    input wire logic ctl_wr, // Ctl write
    input wire logic [15:0] ctl_data, // Ctl word
    input wire logic cal_wr, // Cal write
    input wire logic cal_rd, // Cal read
    input wire logic byte_mode, // Byte bus
    input wire logic high_byte_select, // High byte
    input wire logic [15:0] rd_data, // Read data
    input wire logic [1:0] power_state, // Power
    input wire logic [1:0] cal_target, // Target
    input wire logic [3:0] cal_index // Pointer
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] rdt_q;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Own copy of read target, so checks need not peek inside
    always_ff @(posedge clock or posedge sys_rst)
        if (sys_rst)
            rdt_q <= 2'h0;
        else if (ctl_wr)
            rdt_q <= ctl_data[7:6];
    sequence s_step;
        (cal_rd || cal_wr) && !ctl_wr && (!byte_mode || high_byte_select);
    endsequence
    property p_stat;
        rdt_q == 2'h3 && $past(rdt_q) == 2'h3 && !$past(byte_mode)
            |-> rd_data[15:10] == 6'h00 && rd_data[7:6] == 2'h3;
    endproperty
    a_stat: assert property (p_stat) else $error("status fixed bits");
    property p_lead;
        rdt_q == 2'h2 && $past(rdt_q) == 2'h2 |-> rd_data[15:14] == 2'h0;
    endproperty
    a_lead: assert property (p_lead) else $error("cal lead bits");
    property p_restart;
        ctl_wr && !ctl_data[0] |=> cal_index ==
            (($past(ctl_data[2:1]) == 2'h2) ? 4'h1 : 4'h0);
    endproperty
    a_restart: assert property (p_restart) else $error("restart");
    property p_adv;
        s_step ##0 (cal_target == 2'h0 && cal_index != 4'h9)
            |=> cal_index == $past(cal_index) + 4'h1;
    endproperty
    a_adv: assert property (p_adv) else $error("advance");
    property p_wrap;
        s_step ##0 (cal_target == 2'h0 && cal_index == 4'h9 ||
            cal_target == 2'h1 && cal_index == 4'h1) |=> cal_index == 4'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap");
    property p_single;
        s_step ##0 cal_target[1] |=> $stable(cal_index);
    endproperty
    a_single: assert property (p_single) else $error("single");
    property p_low;
        (cal_rd || cal_wr) && !ctl_wr && byte_mode && !high_byte_select
            |=> $stable(cal_index);
    endproperty
    a_low: assert property (p_low) else $error("low byte");
    property p_tgt;
        ctl_wr && !ctl_data[0] |=> cal_target == $past(ctl_data[2:1]);
    endproperty
    a_tgt: assert property (p_tgt) else $error("target");
    property p_pwr;
        ctl_wr |=> power_state == $past(ctl_data[9:8]);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power");
endmodule
bind acr_regs acr_chk i_chk (.clock, .sys_rst, .ctl_wr, .ctl_data, .cal_wr,
    .cal_rd, .byte_mode, .high_byte_select, .rd_data, .power_state,
    .cal_target, .cal_index);

// ### test/acr_host.sv
module acr_host (
    input wire logic clock, // Clock
    output logic ctl_wr, // Ctl write
    output logic [15:0] ctl_data, // Ctl word
    output logic cal_wr, // Cal write
    output logic cal_rd, // Cal read
    output logic high_byte_select, // High byte
    output logic [15:0] wr_data // Write data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {ctl_wr, ctl_data, cal_wr, cal_rd, high_byte_select, wr_data} = '0;
    // Kind is {ctl, wr, rd}; released buses show inverse data
    task automatic put(input logic [2:0] kind, input logic [15:0] d,
        input logic hb);
        @(posedge clock);
        #1;
        {ctl_wr, cal_wr, cal_rd} = kind;
        ctl_data = d;
        wr_data = d;
        high_byte_select = hb;
        @(posedge clock);
        #1;
        {ctl_wr, cal_wr, cal_rd} = 3'h0;
        ctl_data = ~d;
        wr_data = ~d;
    endtask
endmodule

// ### test/test_acr_regs.sv
module test_acr_regs;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 0, sys_rst = 1, byte_mode = 0, conv_active = 0;
    logic cal_active = 0, cal_update = 0;
    logic [3:0] cal_update_idx = 4'h0;
    logic [13:0] cal_update_data = 14'h0000;
    logic ctl_wr, cal_wr, cal_rd, high_byte_select, input_range_select;
    logic cal_type_select, cal_launch, conv_start;
    logic [15:0] ctl_data, wr_data, rd_data;
    logic [1:0] power_state, cal_target;
    logic [3:0] cal_index;
    int n_mismatch = 0, total_checks = 0;
    acr_host i_host (.clock, .ctl_wr, .ctl_data, .cal_wr, .cal_rd,
        .high_byte_select, .wr_data);
    acr_regs i_dut (.clock, .sys_rst, .ctl_wr, .ctl_data, .cal_wr, .cal_rd,
        .byte_mode, .high_byte_select, .wr_data, .conv_active, .cal_active,
        .cal_update, .cal_update_idx, .cal_update_data, .rd_data,
        .power_state, .input_range_select, .cal_type_select, .cal_launch,
        .conv_start, .cal_target, .cal_index);
    task automatic chk(input string what, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic ctl(input logic [15:0] d);
        i_host.put(3'h4, d, 1'b0);
    endtask
    task automatic rd(input logic hb, input logic [15:0] exp);
        i_host.put(3'h1, 16'h0000, hb);
        chk("rd_data", rd_data, exp);
    endtask
    // Status is sampled late enough for a registered busy path
    task automatic look(input logic [15:0] exp);
        repeat (2) @(posedge clock);
        #1;
        chk("status", rd_data, exp);
    endtask
    task automatic ptr(input logic [15:0] exp);
        chk("cal_index", {12'h000, cal_index}, exp);
    endtask
    initial forever #2 clock = ~clock;
    initial
    begin
        #20000;
        n_mismatch++;
        end_of_test();
    end
    initial
    begin
        repeat (3) @(posedge clock);
        #1;
        sys_rst = 0;
        chk("fields", {4'h0, power_state, cal_target, input_range_select,
            cal_type_select, cal_launch, conv_start, cal_index}, 16'h0);
        ctl(16'h00C0);
        look(16'h00C0);
        ctl(16'h03EC);
        chk("fields", {10'h000, power_state, input_range_select,
            cal_type_select, cal_target}, 16'h003E);
        for (int k = 1; k < 3; k++)
        begin
            {cal_active, conv_active} = k[1:0];
            look({15'h01FE, k[1]});
        end
        {cal_active, conv_active} = 2'h0;
        ctl(16'h0000);
        for (int i = 0; i < 10; i++)
        begin
            i_host.put(3'h2, 16'hC0A0 + 16'(i), 1'b0);
            ptr(16'((i + 1) % 10));
        end
        @(posedge clock);
        #1;
        {cal_update, cal_update_idx, cal_update_data} = {5'h11, 14'h1234};
        @(posedge clock);
        #1;
        cal_update = 0;
        ctl(16'h0080);
        for (int i = 0; i < 10; i++)
            rd(1'b0, i == 1 ? 16'h1234 : 16'h00A0 + 16'(i));
        ptr(16'h0000);
        for (int t = 1; t < 4; t++)
        begin
            ctl(16'h0080 | 16'(t << 1));
            for (int j = 0; j < 3; j++)
                rd(1'b0, (t == 2 || t == 1 && j == 1) ? 16'h1234 : 16'h00A0);
        end
        rd(1'b0, 16'h00A0);
        ctl(16'h0080);
        rd(1'b0, 16'h00A0);
        byte_mode = 1;
        ctl(16'h0080);
        rd(1'b0, 16'h00A0);
        ptr(16'h0000);
        rd(1'b1, 16'h0000);
        ptr(16'h0001);
        rd(1'b0, 16'h0034);
        rd(1'b1, 16'h0012);
        ctl(16'h0000);
        i_host.put(3'h2, 16'h0055, 1'b0);
        ptr(16'h0000);
        i_host.put(3'h2, 16'h0011, 1'b1);
        ptr(16'h0001);
        ctl(16'h0080);
        rd(1'b0, 16'h0055);
        rd(1'b1, 16'h0011);
        cal_active = 1;
        ctl(16'h0011);
        chk("launch", {14'h0000, cal_launch, conv_start}, 16'h0003);
        ptr(16'h0001);
        @(posedge clock);
        #1;
        chk("launch", {14'h0000, cal_launch, conv_start}, 16'h0002);
        cal_active = 0;
        @(posedge clock);
        #1;
        chk("launch", {14'h0000, cal_launch, conv_start}, 16'h0000);
        end_of_test();
    end
endmodule
